//--- src/automatic_gain_switching.sv
// Automatic gain set switching with AXI4-Lite register access
//
// Summary of operation
// - Automatic switching happens only while the drive is in position control.
// - In auto mode, condition A true moves set 1 to set 2 using times 1.
// - In auto mode, condition A false moves set 2 to set 1 using times 2.
// - Selector 0..3: done on, done off, near on, near off define condition A.
// - Selector 4: filter idle and reference off; selector 5: reference active.
// - Outside position control, set 1 fixed for 0,2,4 and set 2 for 1,3,5.
// - After condition A changes, the waiting time elapses before the ramp starts.
// - Each active gain moves linearly to its target within the switching time.
// - Automatic switching only with PI or I-P speed control law selected.
// - Position loop gain switches between sets; range 10..20000, default 400.
// - Model following gains per set; range 10..20000, default 500.
// - Model following compensation per set; range 500..2000, default 1000.
// - Torque filter time constants per set; range 0..65535, default 100.
// - Friction compensation gains per set; range 10..1000, default 100.
// - Mode field: 0 manual (default), 2 automatic, 1 reserved.
// - Waiting and switching times range 0..65535 ms, default 0.
//
// Chosen here: the register addresses and the AXI4-Lite register port.
module automatic_gain_switching #(
  parameter int MS_CYCLES = gain_switch_pkg::MS_CYCLES_DEF
) (
  input  wire logic                               aclk,
  input  wire logic                               aresetn,
  input  wire logic [gain_switch_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                               awvalid,
  output logic                                    awready,
  input  wire logic [31:0]                        wdata,
  input  wire logic [3:0]                         wstrb,
  input  wire logic                               wvalid,
  output logic                                    wready,
  output logic      [1:0]                         bresp,
  output logic                                    bvalid,
  input  wire logic                               bready,
  input  wire logic [gain_switch_pkg::ADDR_W-1:0] araddr,
  input  wire logic                               arvalid,
  output logic                                    arready,
  output logic      [31:0]                        rdata,
  output logic      [1:0]                         rresp,
  output logic                                    rvalid,
  input  wire logic                               rready,
  input  wire logic                               position_control,
  input  wire logic                               positioning_done_flag,
  input  wire logic                               positioning_near_flag,
  input  wire logic                               ref_filter_idle,
  input  wire logic                               ref_input_active,
  output logic      [15:0]                        active_speed_gain,
  output logic      [15:0]                        active_speed_integral,
  output logic      [15:0]                        active_position_gain,
  output logic      [15:0]                        active_torque_filter,
  output logic      [15:0]                        active_model_gain,
  output logic      [15:0]                        active_model_comp,
  output logic      [15:0]                        active_friction_gain,
  output logic                                    active_set,
  output logic                                    gain_switching
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0]  cfg_q;
  logic [1:0]  law_q;
  logic [15:0] wait1_q;
  logic [15:0] wait2_q;
  logic [15:0] ramp1_q;
  logic [15:0] ramp2_q;
  logic [15:0] gain_q [0:gain_switch_pkg::NGAIN-1];

  logic        awready_q;
  logic        arready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;

  gain_switch_pkg::sw_state_t state_q;
  logic                       set_q;
  logic                       busy_q;
  logic [gain_switch_pkg::CNT_W-1:0] cnt_q;
  logic [gain_switch_pkg::CNT_W-1:0] ramp_total_q;
  logic [15:0]                lane_val [0:gain_switch_pkg::LANES-1];

  ////////////////////////////////////////////////////////////////////////////
  // Condition A and enable decode
  wire [3:0] mode_sel = cfg_q[gain_switch_pkg::CFG_MODE_LSB +: 4];
  wire [3:0] cond_sel = cfg_q[gain_switch_pkg::CFG_COND_LSB +: 4];

  wire cond_a =
    (cond_sel == gain_switch_pkg::COND_DONE_ON)  ? positioning_done_flag :
    (cond_sel == gain_switch_pkg::COND_DONE_OFF) ? !positioning_done_flag :
    (cond_sel == gain_switch_pkg::COND_NEAR_ON)  ? positioning_near_flag :
    (cond_sel == gain_switch_pkg::COND_NEAR_OFF) ? !positioning_near_flag :
    (cond_sel == gain_switch_pkg::COND_REF_IDLE) ?
      (ref_filter_idle && !ref_input_active) :
    (cond_sel == gain_switch_pkg::COND_REF_ON)   ? ref_input_active :
    1'b0;

  // Undefined selector codes fall back to set 1
  wire fixed_set = (cond_sel <= gain_switch_pkg::COND_REF_ON) && cond_sel[0];

  wire law_ok = (law_q == gain_switch_pkg::LAW_PI) ||
                (law_q == gain_switch_pkg::LAW_IP);
  // Reserved mode 1 behaves like manual
  wire auto_on = (mode_sel == gain_switch_pkg::MODE_AUTO);
  wire auto_ok = position_control && auto_on && law_ok;

  // Manual mode inside position control keeps whatever set is active
  wire want_set = auto_ok ? cond_a :
                  !position_control ? fixed_set :
                  set_q;

  // Set 2 is entered with times 1, set 1 with times 2
  wire [15:0] wait_ms = want_set ? wait1_q : wait2_q;
  wire [15:0] ramp_ms = want_set ? ramp1_q : ramp2_q;
  wire [gain_switch_pkg::CNT_W-1:0] wait_cycles =
    gain_switch_pkg::CNT_W'(wait_ms) * gain_switch_pkg::CNT_W'(MS_CYCLES);
  wire [gain_switch_pkg::CNT_W-1:0] ramp_cycles =
    gain_switch_pkg::CNT_W'(ramp_ms) * gain_switch_pkg::CNT_W'(MS_CYCLES);

  wire differs    = want_set != set_q;
  wire cnt_zero   = cnt_q == '0;
  wire in_wait    = state_q == gain_switch_pkg::ST_WAIT;
  wire in_ramp    = state_q == gain_switch_pkg::ST_RAMP;
  wire cancel     = in_wait && (!auto_ok || !differs);
  wire start_ramp = in_wait && !cancel && cnt_zero;
  wire ramp_abort = in_ramp && !position_control;
  wire ramp_step  = in_ramp && !cnt_zero && !ramp_abort;
  wire lane_fin   = !in_ramp || cnt_zero || ramp_abort;
  wire tgt_set    = start_ramp ? want_set : set_q;

  ////////////////////////////////////////////////////////////////////////////
  // Switching sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q      <= gain_switch_pkg::ST_HOLD;
      set_q        <= 1'b0;
      cnt_q        <= '0;
      ramp_total_q <= '0;
      busy_q       <= 1'b0;
    end else begin
      unique case (state_q)
        gain_switch_pkg::ST_HOLD: begin
          if (differs && auto_ok) begin
            state_q <= gain_switch_pkg::ST_WAIT;
            cnt_q   <= wait_cycles;
          end else if (differs) begin
            set_q <= want_set;
          end
        end
        gain_switch_pkg::ST_WAIT: begin
          if (cancel) begin
            state_q <= gain_switch_pkg::ST_HOLD;
          end else if (cnt_zero) begin
            state_q      <= gain_switch_pkg::ST_RAMP;
            set_q        <= want_set;
            cnt_q        <= ramp_cycles;
            ramp_total_q <= ramp_cycles;
            busy_q       <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        gain_switch_pkg::ST_RAMP: begin
          if (cnt_zero || ramp_abort) begin
            state_q <= gain_switch_pkg::ST_HOLD;
            busy_q  <= 1'b0;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: begin
          state_q <= gain_switch_pkg::ST_HOLD;
          busy_q  <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gain lanes; outside a ramp each lane tracks its selected register
  for (genvar l = 0; l < gain_switch_pkg::LANES; l++) begin : g_lane
    wire [15:0] lane_tgt = tgt_set ? gain_q[l + gain_switch_pkg::LANES] : gain_q[l];
    gain_ramp #(
      .RESET_VALUE (gain_switch_pkg::GAIN_RESET[l])
    ) u_ramp (
      .aclk    (aclk),
      .aresetn (aresetn),
      .load    (start_ramp),
      .step    (ramp_step),
      .finish  (lane_fin),
      .target  (lane_tgt),
      .total   (ramp_total_q),
      .value   (lane_val[l])
    );
  end

  assign active_speed_gain     = lane_val[0];
  assign active_speed_integral = lane_val[1];
  assign active_position_gain  = lane_val[2];
  assign active_torque_filter  = lane_val[3];
  assign active_model_gain     = lane_val[4];
  assign active_model_comp     = lane_val[5];
  assign active_friction_gain  = lane_val[6];
  assign active_set            = set_q;
  assign gain_switching        = busy_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register view and decode
  logic [31:0] view [0:31];
  logic [31:0] mapped;

  always_comb begin
    for (int i = 0; i < 32; i++) begin
      view[i] = 32'h00000000;
    end
    mapped = 32'h00000000;
    view[gain_switch_pkg::IDX_CONFIG] = {24'h000000, cfg_q};
    view[gain_switch_pkg::IDX_LAW]    = {30'h00000000, law_q};
    view[gain_switch_pkg::IDX_WAIT1]  = {16'h0000, wait1_q};
    view[gain_switch_pkg::IDX_WAIT2]  = {16'h0000, wait2_q};
    view[gain_switch_pkg::IDX_RAMP1]  = {16'h0000, ramp1_q};
    view[gain_switch_pkg::IDX_RAMP2]  = {16'h0000, ramp2_q};
    view[gain_switch_pkg::IDX_STATUS] = {27'h0000000, auto_ok, cond_a, in_ramp, in_wait, set_q};
    for (int i = 0; i <= 6; i++) begin
      mapped[i] = 1'b1;
    end
    for (int i = 0; i < gain_switch_pkg::LANES; i++) begin
      view[gain_switch_pkg::IDX_SET1 + i] = {16'h0000, gain_q[i]};
      view[gain_switch_pkg::IDX_SET2 + i] = {16'h0000, gain_q[i + gain_switch_pkg::LANES]};
      mapped[gain_switch_pkg::IDX_SET1 + i] = 1'b1;
      mapped[gain_switch_pkg::IDX_SET2 + i] = 1'b1;
    end
  end

  wire [4:0]  widx   = awaddr[gain_switch_pkg::ADDR_W-1:2];
  wire [4:0]  ridx   = araddr[gain_switch_pkg::ADDR_W-1:2];
  wire [31:0] wold   = view[widx];
  wire [15:0] wmerge = {wstrb[1] ? wdata[15:8] : wold[15:8],
                        wstrb[0] ? wdata[7:0]  : wold[7:0]};
  wire        aw_take = awvalid && wvalid && !awready_q && !bvalid_q;
  wire        wr_en   = awready_q && mapped[widx] && (widx != gain_switch_pkg::IDX_STATUS);
  wire        ar_take = arvalid && !arready_q && !rvalid_q;

  function automatic logic [15:0] clamp(input logic [15:0] v,
                                        input logic [15:0] lo,
                                        input logic [15:0] hi);
    clamp = (v < lo) ? lo : (v > hi) ? hi : v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q   <= gain_switch_pkg::CFG_RESET;
      law_q   <= gain_switch_pkg::LAW_RESET;
      wait1_q <= gain_switch_pkg::TIME_RESET;
      wait2_q <= gain_switch_pkg::TIME_RESET;
      ramp1_q <= gain_switch_pkg::TIME_RESET;
      ramp2_q <= gain_switch_pkg::TIME_RESET;
      for (int i = 0; i < gain_switch_pkg::NGAIN; i++) begin
        gain_q[i] <= gain_switch_pkg::GAIN_RESET[i % gain_switch_pkg::LANES];
      end
    end else if (wr_en) begin
      if (widx == gain_switch_pkg::IDX_CONFIG && wstrb[0]) cfg_q <= wdata[7:0];
      if (widx == gain_switch_pkg::IDX_LAW && wstrb[0]) law_q <= wdata[1:0];
      if (widx == gain_switch_pkg::IDX_WAIT1) wait1_q <= wmerge;
      if (widx == gain_switch_pkg::IDX_WAIT2) wait2_q <= wmerge;
      if (widx == gain_switch_pkg::IDX_RAMP1) ramp1_q <= wmerge;
      if (widx == gain_switch_pkg::IDX_RAMP2) ramp2_q <= wmerge;
      // Out-of-range writes saturate so the loops never see illegal gains
      for (int i = 0; i < gain_switch_pkg::LANES; i++) begin
        if (widx == gain_switch_pkg::IDX_SET1 + 5'(i)) begin
          gain_q[i] <= clamp(wmerge, gain_switch_pkg::GAIN_MIN[i],
                             gain_switch_pkg::GAIN_MAX[i]);
        end
        if (widx == gain_switch_pkg::IDX_SET2 + 5'(i)) begin
          gain_q[i + gain_switch_pkg::LANES] <= clamp(wmerge,
            gain_switch_pkg::GAIN_MIN[i], gain_switch_pkg::GAIN_MAX[i]);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite handshakes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= gain_switch_pkg::RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= gain_switch_pkg::RESP_OKAY;
      rdata_q   <= 32'h00000000;
    end else begin
      awready_q <= aw_take;
      if (awready_q) begin
        bvalid_q <= 1'b1;
        bresp_q  <= mapped[widx] ? gain_switch_pkg::RESP_OKAY : gain_switch_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid_q <= 1'b0;
      end
      arready_q <= ar_take;
      if (arready_q) begin
        rvalid_q <= 1'b1;
        rdata_q  <= view[ridx];
        rresp_q  <= mapped[ridx] ? gain_switch_pkg::RESP_OKAY : gain_switch_pkg::RESP_SLVERR;
      end else if (rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign awready = awready_q;
  assign wready  = awready_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rresp   = rresp_q;
  assign rdata   = rdata_q;

  // Clamp ranges: position gain and torque filter share the generic saturation

endmodule

//--- src/gain_switch_pkg.sv
// Constants and types for the automatic gain switching block
package gain_switch_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Gain lanes: 0 speed gain, 1 integral time, 2 position gain,
  // 3 torque filter, 4 model following gain, 5 model following comp, 6 friction
  localparam int LANES = 7;
  localparam int NGAIN = 14;

  localparam logic [15:0] GAIN_RESET [0:LANES-1] = '{
    16'h0190, 16'h07d0, 16'h0190, 16'h0064, 16'h01f4, 16'h03e8, 16'h0064};
  localparam logic [15:0] GAIN_MIN [0:LANES-1] = '{
    16'h000a, 16'h000f, 16'h000a, 16'h0000, 16'h000a, 16'h01f4, 16'h000a};
  localparam logic [15:0] GAIN_MAX [0:LANES-1] = '{
    16'h4e20, 16'hc800, 16'h4e20, 16'hffff, 16'h4e20, 16'h07d0, 16'h03e8};

  ////////////////////////////////////////////////////////////////////////////
  // Register word indices; byte address is four times the index
  localparam logic [4:0] IDX_CONFIG   = 5'h00;
  localparam logic [4:0] IDX_LAW      = 5'h01;
  localparam logic [4:0] IDX_WAIT1    = 5'h02;
  localparam logic [4:0] IDX_WAIT2    = 5'h03;
  localparam logic [4:0] IDX_RAMP1    = 5'h04;
  localparam logic [4:0] IDX_RAMP2    = 5'h05;
  localparam logic [4:0] IDX_STATUS   = 5'h06;
  localparam logic [4:0] IDX_SET1     = 5'h08;
  localparam logic [4:0] IDX_SET2     = 5'h10;
  localparam int         ADDR_W       = 7;

  // Configuration fields
  localparam int         CFG_MODE_LSB = 0;
  localparam int         CFG_COND_LSB = 4;
  localparam logic [7:0] CFG_RESET    = 8'h00;
  localparam logic [3:0] MODE_MANUAL  = 4'h0;
  localparam logic [3:0] MODE_AUTO    = 4'h2;
  localparam logic [3:0] COND_DONE_ON = 4'h0;
  localparam logic [3:0] COND_DONE_OFF = 4'h1;
  localparam logic [3:0] COND_NEAR_ON = 4'h2;
  localparam logic [3:0] COND_NEAR_OFF = 4'h3;
  localparam logic [3:0] COND_REF_IDLE = 4'h4;
  localparam logic [3:0] COND_REF_ON  = 4'h5;

  // Control law selection
  localparam logic [1:0] LAW_PI       = 2'h0;
  localparam logic [1:0] LAW_IP       = 2'h1;
  localparam logic [1:0] LAW_RESET    = 2'h0;
  localparam logic [15:0] TIME_RESET  = 16'h0000;

  // Status bits
  localparam int ST_SET_BIT  = 0;
  localparam int ST_WAIT_BIT = 1;
  localparam int ST_RAMP_BIT = 2;
  localparam int ST_COND_BIT = 3;
  localparam int ST_AUTO_BIT = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
  localparam int CNT_W         = 40;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_WAIT = 2'b01,
    ST_RAMP = 2'b11
  } sw_state_t;

endpackage

//--- src/gain_ramp.sv
// One gain lane: linear ramp from current value to a target
module gain_ramp #(
  parameter logic [15:0] RESET_VALUE = 16'h0000
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        load,
  input  wire logic        step,
  input  wire logic        finish,
  input  wire logic [15:0] target,
  input  wire logic [39:0] total,
  output logic      [15:0] value
);

  logic [15:0] value_q;
  logic [15:0] mag_q;
  logic        down_q;
  logic [39:0] acc_q;

  wire  [39:0] acc_sum = acc_q + {24'h000000, mag_q};
  wire         over    = acc_sum >= total;
  wire         below   = target < value_q;
  wire  [15:0] diff_up = target - value_q;
  wire  [15:0] diff_dn = value_q - target;

  // Error accumulator spreads the unit steps evenly over the ramp
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      value_q <= RESET_VALUE;
      mag_q   <= 16'h0000;
      down_q  <= 1'b0;
      acc_q   <= 40'h0000000000;
    end else if (load) begin
      down_q <= below;
      mag_q  <= below ? diff_dn : diff_up;
      acc_q  <= 40'h0000000000;
    end else if (finish) begin
      value_q <= target;
    end else if (step) begin
      if (over && value_q != target) begin
        acc_q   <= acc_sum - total;
        value_q <= down_q ? value_q - 16'h0001 : value_q + 16'h0001;
      end else begin
        acc_q <= acc_sum;
      end
    end
  end

  assign value = value_q;

endmodule

//--- verification/automatic_gain_switching_asserts.sv
// Port checker for the automatic gain switching block
module gain_switch_checker #(
  parameter int MS_CYCLES = 4
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic        position_control,
  input wire logic [15:0] active_position_gain,
  input wire logic        active_set,
  input wire logic        gain_switching
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  a_write_answer: assert property (awvalid && wvalid && !awready && !bvalid
    |-> ##1 (awready && wready) ##1 (bvalid && !awready)) else $error("write answer late");
  a_read_answer: assert property (arvalid && !arready && !rvalid
    |-> ##1 arready ##1 rvalid) else $error("read answer late");
  a_bvalid_holds: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped");
  a_rdata_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_factory_set: assert property ($rose(aresetn) |-> !active_set && !gain_switching
    && active_position_gain == 16'h0190) else $error("reset gain wrong");
  // Two cycles low so that a registered abort has landed
  a_fixed_outside: assert property (!position_control [*2] |-> !gain_switching)
    else $error("switching outside position control");
  a_ramp_cause: assert property ($rose(gain_switching) |-> $past(position_control))
    else $error("ramp without position control");
  a_ramp_set_holds: assert property (gain_switching && $past(gain_switching)
    |-> $stable(active_set)) else $error("set changed mid ramp");
endmodule
bind automatic_gain_switching gain_switch_checker #(.MS_CYCLES(MS_CYCLES)) u_check (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .arvalid,
  .arready, .rvalid, .rready, .rdata, .position_control, .active_position_gain,
  .active_set, .gain_switching);

//--- verification/servo_loop_model.sv
// Servo loop model driving the switching condition inputs
module servo_loop_model (
  input  wire logic       aclk,
  input  wire logic       in_pos,
  input  wire logic [3:0] c_sel,
  input  wire logic       c_true,
  output logic            position_control,
  output logic            positioning_done_flag,
  output logic            positioning_near_flag,
  output logic            ref_filter_idle,
  output logic            ref_input_active
);
  logic tog_q = 1'b0;
  // Unselected flags wander, so a wrong decode shows
  always_ff @(posedge aclk) begin
    tog_q <= ~tog_q;
  end
  assign position_control = in_pos;
  assign positioning_done_flag = c_sel == 4'h0 ? c_true : c_sel == 4'h1 ? !c_true : tog_q;
  assign positioning_near_flag = c_sel == 4'h2 ? c_true : c_sel == 4'h3 ? !c_true : tog_q;
  assign ref_filter_idle = c_sel == 4'h4 ? c_true : tog_q;
  assign ref_input_active = c_sel == 4'h5 ? c_true : c_sel == 4'h4 ? 1'b0 : tog_q;
endmodule

//--- verification/tb_automatic_gain_switching.sv
// Self-checking bench for the automatic gain switching block
module tb_automatic_gain_switching;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 4;
  logic        aclk = 1'b0, aresetn = 1'b0, in_pos = 1'b0, c_true = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [6:0]  awaddr = 7'h00, araddr = 7'h00;
  logic [31:0] wdata = 32'h0, rdata, rv, seed = 32'h2b4;
  logic [3:0]  wstrb = 4'h0, c_sel = 4'h0;
  logic [1:0]  bresp, rresp, rr;
  logic        awready, wready, bvalid, arready, rvalid, active_set, gain_switching;
  logic        position_control, positioning_done_flag, positioning_near_flag;
  logic        ref_filter_idle, ref_input_active;
  logic [15:0] active_speed_gain, active_speed_integral, active_position_gain, s [0:13];
  logic [15:0] active_torque_filter, active_model_gain, active_model_comp, active_friction_gain;
  int          error_cnt = 0, n_compared = 0, cyc;
  always #4 aclk = ~aclk;
  automatic_gain_switching #(.MS_CYCLES(MS)) dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .position_control, .positioning_done_flag, .positioning_near_flag, .ref_filter_idle,
    .ref_input_active, .active_speed_gain, .active_speed_integral, .active_position_gain,
    .active_torque_filter, .active_model_gain, .active_model_comp, .active_friction_gain,
    .active_set, .gain_switching);
  servo_loop_model far (.aclk, .in_pos, .c_sel, .c_true, .position_control,
    .positioning_done_flag, .positioning_near_flag, .ref_filter_idle, .ref_input_active);
  ////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] lim(input int l, input logic [15:0] v);
    if (v < gain_switch_pkg::GAIN_MIN[l]) return gain_switch_pkg::GAIN_MIN[l];
    return v > gain_switch_pkg::GAIN_MAX[l] ? gain_switch_pkg::GAIN_MAX[l] : v;
  endfunction
  function automatic logic [6:0] ga(input int k);
    return 7'h20 + 7'(4 * k) + (k > 6 ? 7'h04 : 7'h00);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Ready comes late on purpose, so the slave must hold its answer
  task automatic bus(input logic we, input logic [6:0] a, input logic [31:0] d);
    @(posedge aclk);
    {awaddr, araddr, wdata, wstrb} <= {a, a, d, 2'(xs()), 2'h3};
    {awvalid, wvalid, arvalid} <= {we, we, !we};
    for (int i = 0; i < 64; i++) begin
      @(posedge aclk);
      if ((awready | arready) === 1'b1) {awvalid, wvalid, arvalid} <= 3'h0;
      if ((bvalid & bready | rvalid & rready) === 1'b1) begin
        rv = rdata;
        rr = we ? bresp : rresp;
        {bready, rready} <= 2'h0;
        return;
      end
      if (i == 2) {bready, rready} <= {we, !we};
    end
    error_cnt++;
    summarize();
  endtask
  task automatic wset(input logic v);
    for (cyc = 0; active_set !== v && cyc < 200; cyc++) @(posedge aclk);
    chk({31'h0, active_set}, {31'h0, v});
    if (cyc == 200) summarize();
  endtask
  task automatic ramp(input int len, input int a, input int b);
    logic [15:0] m;
    int          n;
    m = 16'h0;
    for (n = 0; gain_switching === 1'b1 && n < 200; n++) begin
      @(posedge aclk);
      if (n + 1 == len / 2) m = active_position_gain;
    end
    @(posedge aclk);
    chk({31'h0, n >= len - 1 && n <= len + 2}, 32'h1);
    chk({31'h0, m >= s[a] && m <= s[b] || m <= s[a] && m >= s[b]}, 32'h1);
    chk({16'h0, active_position_gain}, {16'h0, s[b]});
    chk({16'h0, active_speed_gain}, {16'h0, s[b - 2]});
  endtask
  initial begin
    repeat (60000) @(posedge aclk);
    error_cnt++;
    summarize();
  end
  initial begin
    logic [15:0] v;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 0; k < 20; k++) begin
      bus(1'b0, k < 14 ? ga(k) : 7'(4 * (k - 14)), 32'h0);
      chk(rv, k < 14 ? {16'h0, gain_switch_pkg::GAIN_RESET[k % 7]} : 32'h0);
    end
    bus(1'b1, 7'h7c, 32'h1);
    chk({30'h0, rr}, {30'h0, gain_switch_pkg::RESP_SLVERR});
    $display("test factory values done");
    for (int k = 0; k < 14; k++) begin
      v = k == 2 ? 16'h0000 : k == 9 ? 16'hffff : 16'(xs());
      s[k] = lim(k % 7, v);
      bus(1'b1, ga(k), {16'h0, v});
      bus(1'b0, ga(k), 32'h0);
      chk(rv, {16'h0, s[k]});
    end
    for (int k = 0; k < 12; k++) begin
      bus(1'b1, 7'h00, {24'h0, 4'(k % 6), k > 5 ? 4'h2 : 4'h0});
      repeat (3) @(posedge aclk);
      chk({31'h0, active_set}, 32'(k % 2));
      chk({16'h0, active_position_gain}, {16'h0, s[2 + 7 * (k % 2)]});
    end
    $display("test ranges and fixed sets done");
    in_pos <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      c_true <= 1'b0;
      c_sel <= 4'(k);
      bus(1'b1, 7'h00, {24'h0, 4'(k), 4'h2});
      wset(1'b0);
      c_true <= 1'b1;
      wset(1'b1);
    end
    c_true <= 1'b0;
    c_sel <= 4'h0;
    bus(1'b1, 7'h00, 32'h2);
    wset(1'b0);
    bus(1'b1, 7'h08, 32'h1);
    bus(1'b1, 7'h10, 32'h2);
    bus(1'b1, 7'h14, 32'h3);
    c_true <= 1'b1;
    wset(1'b1);
    chk({31'h0, cyc >= MS + 1 && cyc <= MS + 5}, 32'h1);
    ramp(2 * MS, 2, 9);
    c_true <= 1'b0;
    wset(1'b0);
    ramp(3 * MS, 9, 2);
    $display("test timed switching done");
    bus(1'b1, 7'h08, 32'h5);
    c_true <= 1'b1;
    repeat (10) @(posedge aclk);
    c_true <= 1'b0;
    repeat (40) @(posedge aclk);
    chk({30'h0, active_set, gain_switching}, 32'h0);
    bus(1'b1, 7'h08, 32'h0);
    bus(1'b1, 7'h04, 32'h3);
    c_true <= 1'b1;
    repeat (30) @(posedge aclk);
    chk({31'h0, active_set}, 32'h0);
    bus(1'b1, 7'h04, {30'h0, gain_switch_pkg::LAW_IP});
    wset(1'b1);
    $display("test cancel and control law done");
    summarize();
  end
endmodule
